// >>> sim/bps_scrambler_chk.sv
// Purpose: port checks for the burst scrambler
// Assumes: one clock, async active low reset
// Notes:   bound to every scrambler instance
`timescale 1ns/1ps
module bps_scrambler_chk
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic burst_start,
  input wire logic pdu_valid,
  input wire logic pdu_data,
  input wire logic pdu_last,
  input wire logic pdu_ready,
  input wire logic scr_valid,
  input wire logic scr_data,
  input wire logic scr_last,
  input wire logic scr_ready,
  input wire logic burst_active
);
  logic take;
  logic stall;
  // acceptance and downstream stall
  assign take  = pdu_valid && pdu_ready && !burst_start;
  assign stall = scr_valid && !scr_ready;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_hold_valid: assert property (stall |=> scr_valid)
    else $error("valid dropped in stall");
  a_hold_data: assert property (stall |=> $stable(scr_data))
    else $error("data moved in stall");
  a_hold_last: assert property (stall |=> $stable(scr_last))
    else $error("last moved in stall");
  a_ready_idle: assert property (!burst_active |-> !pdu_ready)
    else $error("ready outside burst");
  a_start_opens: assert property (burst_start |=> burst_active)
    else $error("burst not opened");
  // a take during a downstream stall cannot drain, so ready must fall
  a_ready_drop: assert property (take && stall |=> !pdu_ready)
    else $error("ready held after take");
  a_last_close: assert property (take && pdu_last |=> !burst_active)
    else $error("burst not closed");
  a_out_lat: assert property (take |-> ##[2:40] scr_valid)
    else $error("bit never left");
  c_take: cover property (take && pdu_last);
  c_stall: cover property (stall ##1 scr_ready);
  c_full: cover property (burst_active && !pdu_ready && stall);
endmodule : bps_scrambler_chk

bind bps_scrambler bps_scrambler_chk chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .burst_start(burst_start), .pdu_valid(pdu_valid), .pdu_data(pdu_data),
  .pdu_last(pdu_last), .pdu_ready(pdu_ready), .scr_valid(scr_valid),
  .scr_data(scr_data), .scr_last(scr_last), .scr_ready(scr_ready),
  .burst_active(burst_active));

// >>> sim/bps_scrambler_tb_top.sv
// Purpose: self-checking bench for the burst scrambler
// Assumes: sink model on the output side
// Notes:   expected bits come from a bench copy of the sequence
`timescale 1ns/1ps
module bps_scrambler_tb_top;
  typedef struct {logic [15:0] w; int n; logic s;} bps_row_type;
  logic sys_clk = 0, rst_n = 0, burst_start = 0, slow = 0;
  logic pdu_valid = 0, pdu_data = 0, pdu_last = 0;
  logic pdu_ready, scr_valid, scr_data, scr_last, scr_ready, burst_active;
  logic [14:0] lfsr;
  logic q_d[$];
  logic q_l[$];
  int n_mismatch = 0, compares = 0, k;
  // rows are whole serialized fields: listed order, descending bit index,
  // reserved bits ahead of information bits
  bps_row_type rows [4] = '{'{16'h0000, 16, 0}, '{16'hffff, 16, 1},
                            '{16'ha5c3, 16, 0}, '{16'h0001, 1, 1}};
  always #5 sys_clk = ~sys_clk;
  bps_scrambler dut (.sys_clk(sys_clk), .rst_n(rst_n), .burst_start(burst_start),
    .pdu_valid(pdu_valid), .pdu_data(pdu_data), .pdu_last(pdu_last),
    .pdu_ready(pdu_ready), .scr_valid(scr_valid), .scr_data(scr_data),
    .scr_last(scr_last), .scr_ready(scr_ready), .burst_active(burst_active));
  bps_sink sink (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .scr_ready(scr_ready));
  task chk(input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task print_verdict;
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  // reseed the bench copy with the burst
  task start;
    burst_start = 1;
    lfsr = bps_pkg::SEED;
    tick;
    burst_start = 0;
  endtask : start
  // one bit, valid held until the take edge
  task send(input logic b, input logic l);
    logic fb;
    pdu_valid = 1;
    pdu_data = b;
    pdu_last = l;
    for (k = 0; pdu_ready !== 1'b1 && k < 100; k++) tick;
    if (k == 100)
    begin
      n_mismatch++;
      print_verdict;
    end
    @(posedge sys_clk);
    fb = lfsr[13] ^ lfsr[14];
    lfsr = {lfsr[13:0], fb};
    q_d.push_back(b ^ fb);
    q_l.push_back(l);
    #1;
  endtask : send
  // outputs checked mid-cycle, before the edge that takes them, to avoid an edge race
  always @(negedge sys_clk)
    if (rst_n && scr_valid === 1'b1 && scr_ready === 1'b1)
    begin
      chk(q_d.pop_front(), scr_data);
      chk(q_l.pop_front(), scr_last);
    end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    #1;
    chk(1'b0, scr_valid);
    chk(1'b0, pdu_ready);
    rst_n = 1;
    tick;
    foreach (rows[i])
    begin
      slow = rows[i].s;
      start;
      for (int j = rows[i].n - 1; j >= 0; j--) send(rows[i].w[j], j == 0);
      pdu_valid = 0;
      chk(1'b0, burst_active);
      tick;
    end
    // restart mid-burst, valid held high through the strobe
    start;
    send(1, 0);
    send(0, 0);
    start;
    send(1, 0);
    send(0, 1);
    pdu_valid = 0;
    for (k = 0; q_d.size() > 0 && k < 200; k++) tick;
    if (k == 200) n_mismatch++;
    print_verdict;
  end
endmodule : bps_scrambler_tb_top

// >>> sim/bps_sink.sv
// Purpose: crc-side sink model
// Assumes: takes a bit on any edge with scr_ready high
// Notes:   slow mode stalls three cycles of four
`timescale 1ns/1ps
module bps_sink
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic slow,
  output logic      scr_ready
);
  logic [1:0] cnt;
  // free running stall pattern, blind to valid
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  assign scr_ready = rst_n && (!slow || cnt == 2'h3);
endmodule : bps_sink

// >>> verilog/bps_pkg.sv
// Purpose: shared constants for the burst payload scrambler
// Assumes: one 100 MHz clock, bit-serial payload stream
// Notes:   stage numbering follows the shift register, stage one is bit 0
package bps_pkg;

  // shift register length and feedback taps (stage numbers minus one)
  localparam int          LFSR_LEN   = 15;
  localparam int          TAP_A      = 13;
  localparam int          TAP_B      = 14;

  // seed: stage1..stage15 = 1,0,0,1,0,1,0,1,0,0,0,0,0,0,0, stage one in bit 0
  localparam logic [14:0] SEED       = 15'h00_a9;

  // buffer depth and its pointer width
  localparam int          BUF_DEPTH  = 2;
  localparam int          BUF_PTR_W  = 1;

  // run state of the scrambler
  typedef enum logic [0:0] {
    BPS_IDLE,
    BPS_BURST
  } bps_state_type;

endpackage : bps_pkg

// >>> verilog/bps_scrambler.sv
// Purpose: energy-dispersal scrambler for return-link burst payloads
// Assumes: payload arrives bit-serial, preamble already stripped, one clock
// Notes:   output feeds the crc stage; scr_valid, scr_data and scr_last are registered copies of the buffer head
`timescale 1ns/1ps

module bps_scrambler
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic burst_start,
  input  wire logic pdu_valid,
  input  wire logic pdu_data,
  input  wire logic pdu_last,
  output logic      pdu_ready,
  output logic      scr_valid,
  output logic      scr_data,
  output logic      scr_last,
  input  wire logic scr_ready,
  output logic      burst_active
);

  bps_pkg::bps_state_type state;
  bps_pkg::bps_state_type next_state;
  logic [14:0]            lfsr;
  logic [14:0]            next_lfsr;
  logic                   prbs_bit;
  logic                   take;
  logic                   buf_in_ready;
  logic                   buf_valid;
  logic                   buf_data;
  logic                   buf_last;
  logic                   buf_pop;
  logic                   next_scr_valid;
  logic                   next_scr_data;
  logic                   next_scr_last;
  logic                   next_pdu_ready;

  // feedback from stages 14 and 15 (taps of 1 + x^14 + x^15)
  assign prbs_bit = lfsr[bps_pkg::TAP_A] ^ lfsr[bps_pkg::TAP_B];

  // a bit is accepted only inside a burst and only when the buffer has room;
  // a start strobe blocks acceptance that cycle so the seed is in place first
  assign take = pdu_valid && pdu_ready && (state == bps_pkg::BPS_BURST) && !burst_start;

  // sequencer and shift register step
  always_comb
  begin
    next_state = state;
    next_lfsr  = lfsr;
    if (burst_start)
    begin
      next_lfsr  = bps_pkg::SEED;
      next_state = bps_pkg::BPS_BURST;
    end
    else if (take)
    begin
      next_lfsr = {lfsr[13:0], prbs_bit};
      if (pdu_last)
      begin
        next_state = bps_pkg::BPS_IDLE;
      end
    end
    // ready is registered, so drop it after a take that the buffer does not
    // drain in the same cycle; this keeps a push from ever meeting a full buffer
    next_pdu_ready = (next_state == bps_pkg::BPS_BURST) && buf_in_ready
                     && !(take && !buf_pop);
  end

  // the seed is untouched until the first accepted bit, so bit one meets stage output one
  bps_skid_buf u_buf
  (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (take),
    .in_data   (pdu_data ^ prbs_bit),
    .in_last   (pdu_last),
    .in_ready  (buf_in_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_last  (buf_last),
    .out_ready (buf_pop)
  );

  // output register stage; the crc after us sees only scrambled bits
  assign buf_pop = buf_valid && (!scr_valid || scr_ready);

  always_comb
  begin
    next_scr_valid = scr_valid;
    next_scr_data  = scr_data;
    next_scr_last  = scr_last;
    if (buf_pop)
    begin
      next_scr_valid = 1'b1;
      next_scr_data  = buf_data;
      next_scr_last  = buf_last;
    end
    else if (scr_ready)
    begin
      next_scr_valid = 1'b0;
    end
  end

  // registers only
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state        <= bps_pkg::BPS_IDLE;
      lfsr         <= bps_pkg::SEED;
      pdu_ready    <= 1'b0;
      scr_valid    <= 1'b0;
      scr_data     <= 1'b0;
      scr_last     <= 1'b0;
      burst_active <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      lfsr         <= next_lfsr;
      pdu_ready    <= next_pdu_ready;
      scr_valid    <= next_scr_valid;
      scr_data     <= next_scr_data;
      scr_last     <= next_scr_last;
      burst_active <= (next_state == bps_pkg::BPS_BURST);
    end
  end

endmodule : bps_scrambler

// >>> verilog/bps_skid_buf.sv
// Purpose: two-entry valid/ready buffer for the scrambled bit stream
// Assumes: same clock as the scrambler, source honours in_ready
// Notes:   full and empty are exact; in_ready falls only when both entries hold data
`timescale 1ns/1ps

module bps_skid_buf
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic in_valid,
  input  wire logic in_data,
  input  wire logic in_last,
  output logic      in_ready,
  output logic      out_valid,
  output logic      out_data,
  output logic      out_last,
  input  wire logic out_ready
);

  logic [bps_pkg::BUF_DEPTH-1:0] mem_data;
  logic [bps_pkg::BUF_DEPTH-1:0] mem_last;
  logic [bps_pkg::BUF_DEPTH-1:0] next_mem_data;
  logic [bps_pkg::BUF_DEPTH-1:0] next_mem_last;
  logic [bps_pkg::BUF_PTR_W-1:0] wr_ptr;
  logic [bps_pkg::BUF_PTR_W-1:0] rd_ptr;
  logic [bps_pkg::BUF_PTR_W:0]   count;
  logic [bps_pkg::BUF_PTR_W-1:0] next_wr_ptr;
  logic [bps_pkg::BUF_PTR_W-1:0] next_rd_ptr;
  logic [bps_pkg::BUF_PTR_W:0]   next_count;
  logic                          push;
  logic                          pop;

  // flags straight from the occupancy count
  assign in_ready  = (count != 2'(bps_pkg::BUF_DEPTH));
  assign out_valid = (count != 2'h0);
  assign out_data  = mem_data[rd_ptr];
  assign out_last  = mem_last[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and storage update
  always_comb
  begin
    next_mem_data = mem_data;
    next_mem_last = mem_last;
    next_wr_ptr   = wr_ptr;
    next_rd_ptr   = rd_ptr;
    next_count    = count;
    if (push)
    begin
      next_mem_data[wr_ptr] = in_data;
      next_mem_last[wr_ptr] = in_last;
      next_wr_ptr           = wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10:   next_count = count + 2'h1;
      2'b01:   next_count = count - 2'h1;
      default: next_count = count;
    endcase
  end

  // registers only
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_data <= '0;
      mem_last <= '0;
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
    end
    else
    begin
      mem_data <= next_mem_data;
      mem_last <= next_mem_last;
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
    end
  end

endmodule : bps_skid_buf
